// file: core/txdw_device.sv
// device end: write cycle decode, transmit fifo and register write strobe
// assumes bus pins arrive asynchronously and are synchronised here
module txdw_fifo
	import txdw_pkg::*;
#(
	parameter int WIDTH = DATA_W,
	parameter int DEPTH = FIFO_DEPTH
) (
	input  wire logic             clock_i,
	input  wire logic             resetn_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    rd_ptr;
	logic [PW:0]      count;
	logic [PW-1:0]    next_wr_ptr;
	logic [PW-1:0]    next_rd_ptr;
	logic [PW:0]      next_count;
	logic             full;
	logic             nonempty;
	logic             next_full;
	logic             next_nonempty;
	logic             push;
	logic             pop;

	always_comb begin
		push          = in_valid_i && !full;
		pop           = out_ready_i && nonempty;
		next_wr_ptr   = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr   = pop ? rd_ptr + 1'b1 : rd_ptr;
		next_count    = count + (PW+1)'(push) - (PW+1)'(pop);
		next_full     = (next_count == (PW+1)'(DEPTH));
		next_nonempty = (next_count != '0);
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			wr_ptr <= '0;
			rd_ptr   <= '0;
			count    <= '0;
			full     <= 1'b0;
			nonempty <= 1'b0;
		end else begin
			wr_ptr   <= next_wr_ptr;
			rd_ptr   <= next_rd_ptr;
			count    <= next_count;
			full     <= next_full;
			nonempty <= next_nonempty;
		end
	end

	always_ff @(posedge clock_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	assign in_ready_o  = !full;
	assign out_valid_o = nonempty;
	assign out_data_o  = mem[rd_ptr];
endmodule

module txdw_device
	import txdw_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	input  wire logic                   clock_i,
	input  wire logic                   resetn_i,
	txdw_bus_if.device                  bus,
	output logic                        fifo_valid_o,
	input  wire logic                   fifo_ready_i,
	output logic      [DATA_W-1:0]      fifo_data_o,
	output logic      [1:0]             fifo_wsel_o,
	output logic                        reg_wr_o,
	output logic      [ADDR_HI:ADDR_LO] reg_addr_o,
	output logic      [DATA_W-1:0]      reg_data_o,
	output logic                        bus16_o,
	output logic                        overflow_o
);
	localparam int SW = 5 + ADDR_HI - ADDR_LO + 1 + DATA_W;
	localparam int FW = 2 + DATA_W;

	logic [SW-1:0]            sync1;
	logic [SW-1:0]            sync2;
	logic                     cs_s;
	logic                     wr_s;
	logic                     sel_s;
	logic [ADDR_HI:ADDR_LO]   addr_s;
	logic [DATA_W-1:0]        data_s;
	logic                     hrst_s;
	logic                     cfg_s;

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= {bus.device_select_low, bus.write_strobe_low, bus.fifo_sel, bus.addr,
				bus.data, bus.hard_reset_low, bus.cfg_bus16};
			sync2 <= sync1;
		end
	end

	assign {cs_s, wr_s, sel_s, addr_s, data_s, hrst_s, cfg_s} = sync2;

	logic                     active;
	logic                     was_active;
	logic                     hrst_prev;
	logic                     held_sel;
	logic [ADDR_HI:ADDR_LO]   held_addr;
	logic [DATA_W-1:0]        held_data;
	txdw_width_type           width;
	logic                     pend;
	logic [FW-1:0]            pend_word;
	logic                     reg_wr;
	logic [ADDR_HI:ADDR_LO]   reg_addr;
	logic [DATA_W-1:0]        reg_data;
	logic                     overflow;
	logic                     fifo_in_ready;

	logic                     next_was_active;
	logic                     next_hrst_prev;
	logic                     next_held_sel;
	logic [ADDR_HI:ADDR_LO]   next_held_addr;
	logic [DATA_W-1:0]        next_held_data;
	txdw_width_type           next_width;
	logic                     next_pend;
	logic [FW-1:0]            next_pend_word;
	logic                     next_reg_wr;
	logic [ADDR_HI:ADDR_LO]   next_reg_addr;
	logic [DATA_W-1:0]        next_reg_data;
	logic                     next_overflow;
	logic                     cycle_end;
	logic [DATA_W-1:0]        word;

	always_comb begin
		active          = !cs_s && !wr_s && hrst_s;
		cycle_end       = was_active && !active;
		next_was_active = active;
		next_hrst_prev  = hrst_s;
		next_held_sel   = held_sel;
		next_held_addr  = held_addr;
		next_held_data  = held_data;
		next_width      = width;
		next_pend       = pend && !fifo_in_ready;
		next_pend_word  = pend_word;
		next_reg_wr     = 1'b0;
		next_reg_addr   = reg_addr;
		next_reg_data   = reg_data;
		next_overflow   = 1'b0;
		if (!hrst_prev && hrst_s) begin
			next_width = txdw_width_type'(cfg_s);
		end
		if (active) begin
			next_held_sel  = sel_s;
			next_held_addr = addr_s;
			next_held_data = data_s;
		end
		word = (width == TXDW_BUS16) ? {UPPER_ZERO, held_data[HALF_W-1:0]} : held_data;
		if (cycle_end) begin
			if (held_sel) begin
				if (!next_pend) begin
					next_pend      = 1'b1;
					next_pend_word = {held_addr[WSEL_HI:WSEL_LO], word};
				end else begin
					next_overflow = 1'b1;
				end
			end else begin
				next_reg_wr   = 1'b1;
				next_reg_addr = held_addr;
				next_reg_data = word;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			was_active <= 1'b0;
			hrst_prev  <= 1'b0;
			held_sel   <= 1'b0;
			held_addr  <= '0;
			held_data  <= '0;
			width      <= txdw_width_type'(BUS_WIDTH_RESET);
			pend       <= 1'b0;
			pend_word  <= '0;
			reg_wr     <= 1'b0;
			reg_addr   <= '0;
			reg_data   <= '0;
			overflow   <= 1'b0;
		end else begin
			was_active <= next_was_active;
			hrst_prev  <= next_hrst_prev;
			held_sel   <= next_held_sel;
			held_addr  <= next_held_addr;
			held_data  <= next_held_data;
			width      <= next_width;
			pend       <= next_pend;
			pend_word  <= next_pend_word;
			reg_wr     <= next_reg_wr;
			reg_addr   <= next_reg_addr;
			reg_data   <= next_reg_data;
			overflow   <= next_overflow;
		end
	end

	logic [FW-1:0] fifo_out;

	txdw_fifo #(
		.WIDTH (FW),
		.DEPTH (DEPTH)
	) u_fifo (
		.clock_i     (clock_i),
		.resetn_i    (resetn_i),
		.in_valid_i  (pend),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (pend_word),
		.out_valid_o (fifo_valid_o),
		.out_ready_i (fifo_ready_i),
		.out_data_o  (fifo_out)
	);

	assign fifo_wsel_o = fifo_out[FW-1:DATA_W];
	assign fifo_data_o = fifo_out[DATA_W-1:0];
	assign reg_wr_o    = reg_wr;
	assign reg_addr_o  = reg_addr;
	assign reg_data_o  = reg_data;
	assign bus16_o     = width;
	assign overflow_o  = overflow;
endmodule

// file: core/txdw_pkg.sv
// constants and types shared by both ends of the direct fifo write port
// assumes a single 25 MHz clock on both ends
package txdw_pkg;

	localparam int CLK_PERIOD_NS   = 40;
	localparam int DATA_W          = 32;
	localparam int HALF_W          = 16;
	localparam int ADDR_HI         = 7;
	localparam int ADDR_LO         = 1;
	localparam int WSEL_HI         = 2;
	localparam int WSEL_LO         = 1;
	localparam int FIFO_DEPTH      = 32;

	localparam int T_CYCLE_NS      = 45;
	localparam int T_CSL_NS        = 32;
	localparam int T_CSH_NS        = 13;
	localparam int T_CFG_SETUP_NS  = 200;
	localparam int T_CFG_HOLD_NS   = 10;
	localparam int T_RESET_US      = 200;

	// least time in ns to whole cycles, never below one
	function automatic int cyc_min(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int CSL_CYCLES      = cyc_min(T_CSL_NS);
	localparam int CSH_CYCLES      = cyc_min(T_CSH_NS);
	localparam int CYCLE_CYCLES    = cyc_min(T_CYCLE_NS);
	localparam int GAP_CYCLES      = (CYCLE_CYCLES - CSL_CYCLES > CSH_CYCLES) ?
		CYCLE_CYCLES - CSL_CYCLES : CSH_CYCLES;
	localparam int CFG_SETUP_CYCLES = cyc_min(T_CFG_SETUP_NS);
	localparam int CFG_HOLD_CYCLES  = cyc_min(T_CFG_HOLD_NS);
	localparam int RESET_CYCLES    = cyc_min(T_RESET_US * 1000);
	localparam int CNT_W           = 16;

	localparam logic [HALF_W-1:0] UPPER_ZERO = 16'h0000;
	localparam logic              BUS_WIDTH_RESET = 1'b0;

	typedef enum logic {
		TXDW_BUS32 = 1'b0,
		TXDW_BUS16 = 1'b1
	} txdw_width_type;

	typedef enum logic [2:0] {
		TXDW_H_RESET   = 3'b000,
		TXDW_H_CFGHOLD = 3'b001,
		TXDW_H_IDLE    = 3'b010,
		TXDW_H_STROBE  = 3'b011,
		TXDW_H_RECOVER = 3'b100
	} txdw_host_state_type;

endpackage

// file: core/txdw_bus_if.sv
// parallel write bus between host and device
// assumes the testbench supplies clock and reset to the ends, not through the interface
interface txdw_bus_if;
	import txdw_pkg::*;

	logic                   device_select_low;
	logic                   write_strobe_low;
	logic                   fifo_sel;
	logic [ADDR_HI:ADDR_LO] addr;
	logic [DATA_W-1:0]      data;
	logic                   hard_reset_low;
	logic                   cfg_bus16;

	modport host (
		output device_select_low,
		output write_strobe_low,
		output fifo_sel,
		output addr,
		output data,
		output hard_reset_low,
		output cfg_bus16
	);

	modport device (
		input  device_select_low,
		input  write_strobe_low,
		input  fifo_sel,
		input  addr,
		input  data,
		input  hard_reset_low,
		input  cfg_bus16
	);
endinterface

// file: core/txdw_host.sv
// host end: turns user write commands into strobed bus cycles, issues hard reset
// assumes user inputs are on clock_i, no synchronising needed
module txdw_host
	import txdw_pkg::*;
#(
	parameter int RESET_LEN = RESET_CYCLES
) (
	input  wire logic                   clock_i,
	input  wire logic                   resetn_i,
	input  wire logic                   cmd_valid_i,
	output logic                        cmd_ready_o,
	input  wire logic                   cmd_fifo_i,
	input  wire logic [ADDR_HI:ADDR_LO] cmd_addr_i,
	input  wire logic [DATA_W-1:0]      cmd_data_i,
	input  wire logic                   reset_req_i,
	input  wire logic                   cfg_bus16_i,
	txdw_bus_if.host                    bus
);
	txdw_host_state_type    state;
	txdw_host_state_type    next_state;
	logic [CNT_W-1:0]       cnt;
	logic [CNT_W-1:0]       next_cnt;
	logic                   cs_low;
	logic                   next_cs_low;
	logic                   sel;
	logic                   next_sel;
	logic [ADDR_HI:ADDR_LO] addr;
	logic [ADDR_HI:ADDR_LO] next_addr;
	logic [DATA_W-1:0]      data;
	logic [DATA_W-1:0]      next_data;
	logic                   hrst_low;
	logic                   next_hrst_low;
	logic                   cfg;
	logic                   next_cfg;
	logic                   ready;
	logic                   next_ready;

	always_comb begin
		next_state    = state;
		next_cnt      = (cnt != '0) ? cnt - 1'b1 : cnt;
		next_cs_low   = cs_low;
		next_sel      = sel;
		next_addr     = addr;
		next_data     = data;
		next_hrst_low = hrst_low;
		next_cfg      = cfg;
		unique case (state)
			TXDW_H_RESET: begin
				if (cnt == '0) begin
					next_hrst_low = 1'b1;
					next_cnt      = CNT_W'(CFG_HOLD_CYCLES);
					next_state    = TXDW_H_CFGHOLD;
				end
			end
			TXDW_H_CFGHOLD: begin
				if (cnt == '0) begin
					next_state = TXDW_H_IDLE;
				end
			end
			TXDW_H_IDLE: begin
				if (reset_req_i) begin
					next_hrst_low = 1'b0;
					next_cfg      = cfg_bus16_i;
					next_cnt      = CNT_W'(RESET_LEN - 1);
					next_state    = TXDW_H_RESET;
				end else if (cmd_valid_i) begin
					next_sel    = cmd_fifo_i;
					next_addr   = cmd_addr_i;
					next_data   = cmd_data_i;
					next_cs_low = 1'b0;
					next_cnt    = CNT_W'(CSL_CYCLES - 1);
					next_state  = TXDW_H_STROBE;
				end
			end
			TXDW_H_STROBE: begin
				if (cnt == '0) begin
					next_cs_low = 1'b1;
					next_cnt    = CNT_W'(GAP_CYCLES - 1);
					next_state  = TXDW_H_RECOVER;
				end
			end
			TXDW_H_RECOVER: begin
				if (cnt == '0) begin
					next_state = TXDW_H_IDLE;
				end
			end
		endcase
		next_ready = (next_state == TXDW_H_IDLE) && !(state == TXDW_H_IDLE && reset_req_i);
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			state    <= TXDW_H_RESET;
			cnt      <= CNT_W'(RESET_LEN - 1);
			cs_low   <= 1'b1;
			sel      <= 1'b0;
			addr     <= '0;
			data     <= '0;
			hrst_low <= 1'b0;
			cfg      <= 1'b0;
			ready    <= 1'b0;
		end else begin
			state    <= next_state;
			cnt      <= next_cnt;
			cs_low   <= next_cs_low;
			sel      <= next_sel;
			addr     <= next_addr;
			data     <= next_data;
			hrst_low <= next_hrst_low;
			cfg      <= next_cfg;
			ready    <= next_ready;
		end
	end

	assign cmd_ready_o           = ready;
	assign bus.device_select_low = cs_low;
	assign bus.write_strobe_low  = cs_low;
	assign bus.fifo_sel          = sel;
	assign bus.addr              = addr;
	assign bus.data              = data;
	assign bus.hard_reset_low    = hrst_low;
	assign bus.cfg_bus16         = cfg;
endmodule

// file: tb/txdw_asserts.sv
// checker for the write bus joining the host and device ends
// assumes it sits beside the interface, host RESET_LEN at least 5
module txdw_asserts
	import txdw_pkg::*;
(
	input  wire logic                   clock_i,
	input  wire logic                   resetn_i,
	input  wire logic                   device_select_low,
	input  wire logic                   write_strobe_low,
	input  wire logic                   fifo_sel,
	input  wire logic [ADDR_HI:ADDR_LO] addr,
	input  wire logic [DATA_W-1:0]      data,
	input  wire logic                   hard_reset_low,
	input  wire logic                   cfg_bus16
);
	timeunit 1ns;
	timeprecision 1ns;

	default clocking @(posedge clock_i);
	endclocking
	default disable iff (!resetn_i);

	chk_strobe_pair: assert property (device_select_low == write_strobe_low)
		else $error("select and strobe differ");
	chk_low_width: assert property ($fell(device_select_low) |=> device_select_low)
		else $error("strobe low width wrong");
	chk_gap_width: assert property (!device_select_low |-> $past(device_select_low))
		else $error("strobe gap too short");
	chk_sel_hold: assert property ($fell(device_select_low) |=> $stable(fifo_sel) && $stable(addr))
		else $error("select or address moved in cycle");
	chk_data_hold: assert property ($fell(device_select_low) |=> $stable(data))
		else $error("data moved in cycle");
	chk_quiet_reset: assert property (!hard_reset_low |-> device_select_low)
		else $error("cycle during hard reset");
	chk_reset_width: assert property ($fell(hard_reset_low) |-> !hard_reset_low [*5])
		else $error("hard reset too short");
	chk_cfg_setup: assert property ($rose(hard_reset_low) |-> $past(cfg_bus16, 5) == cfg_bus16)
		else $error("strap setup broken");
	chk_cfg_hold: assert property ($rose(hard_reset_low) |=> $stable(cfg_bus16))
		else $error("strap hold broken");
endmodule

// file: tb/tb_tx_fifo_direct_write_port.sv
// testbench joining host and device ends through the bus interface
// assumes 25 MHz clock, host RESET_LEN shortened to 8
module tb_tx_fifo_direct_write_port
	import txdw_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic                   clock_i = 1'b0;
	logic                   resetn_i;
	logic                   cmd_valid;
	logic                   cmd_ready;
	logic                   cmd_fifo;
	logic [ADDR_HI:ADDR_LO] cmd_addr;
	logic [DATA_W-1:0]      cmd_data;
	logic                   reset_req;
	logic                   cfg16;
	logic                   fifo_valid;
	logic                   fifo_ready;
	logic [DATA_W-1:0]      fifo_data;
	logic [1:0]             fifo_wsel;
	logic                   reg_wr;
	logic [ADDR_HI:ADDR_LO] reg_addr;
	logic [DATA_W-1:0]      reg_data;
	logic                   bus16;
	logic                   overflow;
	int                     miscompares = 0;
	int                     check_count = 0;
	int                     overflows = 0;
	int                     regs = 0;
	int                     i;

	always #20 clock_i = ~clock_i;

	always @(posedge clock_i) begin
		if (overflow === 1'b1) overflows++;
		if (reg_wr === 1'b1) regs++;
	end

	txdw_bus_if u_txdw_bus_if();

	txdw_host #(.RESET_LEN(8)) u_txdw_host (.clock_i(clock_i), .resetn_i(resetn_i),
		.cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_fifo_i(cmd_fifo),
		.cmd_addr_i(cmd_addr), .cmd_data_i(cmd_data), .reset_req_i(reset_req),
		.cfg_bus16_i(cfg16), .bus(u_txdw_bus_if));

	txdw_device #(.DEPTH(32)) u_txdw_device (.clock_i(clock_i), .resetn_i(resetn_i),
		.bus(u_txdw_bus_if), .fifo_valid_o(fifo_valid), .fifo_ready_i(fifo_ready),
		.fifo_data_o(fifo_data), .fifo_wsel_o(fifo_wsel), .reg_wr_o(reg_wr),
		.reg_addr_o(reg_addr), .reg_data_o(reg_data), .bus16_o(bus16),
		.overflow_o(overflow));

	txdw_asserts u_txdw_asserts (.clock_i(clock_i), .resetn_i(resetn_i),
		.device_select_low(u_txdw_bus_if.device_select_low),
		.write_strobe_low(u_txdw_bus_if.write_strobe_low),
		.fifo_sel(u_txdw_bus_if.fifo_sel), .addr(u_txdw_bus_if.addr),
		.data(u_txdw_bus_if.data), .hard_reset_low(u_txdw_bus_if.hard_reset_low),
		.cfg_bus16(u_txdw_bus_if.cfg_bus16));

	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask

	task automatic compare(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wait_ready();
		int n;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 200) begin
			tick(1);
			n++;
		end
	endtask

	task automatic bus_write(input logic f, input logic [7:1] a, input logic [31:0] d);
		cmd_valid = 1'b1;
		cmd_fifo = f;
		cmd_addr = a;
		cmd_data = d;
		wait_ready();
		tick(1);
		cmd_valid = 1'b0;
		tick(1);
	endtask

	task automatic hard_reset(input logic w);
		cfg16 = w;
		reset_req = 1'b1;
		wait_ready();
		tick(1);
		reset_req = 1'b0;
		wait_ready();
		tick(4);
	endtask

	task automatic pop(input logic [31:0] d, input logic [1:0] ws);
		int n;
		n = 0;
		while (fifo_valid !== 1'b1 && n < 20) begin
			tick(1);
			n++;
		end
		compare("fifo data", d, fifo_data);
		compare("word select", 32'(ws), 32'(fifo_wsel));
		fifo_ready = 1'b1;
		tick(1);
		fifo_ready = 1'b0;
		tick(1);
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		tick(5000);
		miscompares++;
		end_of_test();
	end

	initial begin
		resetn_i = 1'b0;
		cmd_valid = 1'b0;
		cmd_fifo = 1'b0;
		cmd_addr = '0;
		cmd_data = '0;
		reset_req = 1'b0;
		cfg16 = 1'b0;
		fifo_ready = 1'b0;
		tick(16);
		resetn_i = 1'b1;
		wait_ready();
		tick(4);
		compare("strap", 32'h0000_0000, 32'(bus16));
		bus_write(1'b0, 7'h55, 32'h1234_5678);
		tick(8);
		compare("register writes", 32'h0000_0001, regs);
		compare("register address", 32'h0000_0055, 32'(reg_addr));
		compare("register data", 32'h1234_5678, reg_data);
		compare("fifo idle", 32'h0000_0000, 32'(fifo_valid));
		for (i = 0; i < 34; i++) begin
			bus_write(1'b1, 7'(i * 13), 32'(i) * 32'h0101_0101);
		end
		tick(8);
		compare("dropped words", 32'h0000_0001, overflows);
		for (i = 0; i < 33; i++) begin
			pop(32'(i) * 32'h0101_0101, 2'(i * 13));
		end
		tick(4);
		compare("fifo drained", 32'h0000_0000, 32'(fifo_valid));
		hard_reset(1'b1);
		compare("strap", 32'h0000_0001, 32'(bus16));
		bus_write(1'b1, 7'h7E, 32'hDEAD_BEEF);
		pop(32'h0000_BEEF, 2'h2);
		bus_write(1'b0, 7'h0A, 32'hCAFE_F00D);
		tick(8);
		compare("register data", 32'h0000_F00D, reg_data);
		end_of_test();
	end
endmodule
